// file: verilog/dzrc_pkg.sv
// types and boundary constants of the data zone region classifier
// Overview of operation
// - exactly four defect areas: two at zone start, two at end of band 0.
// - each defect area spans exactly 41 consecutive sectors, only those tagged.
// - groove band 0 defect areas sit on tracks 0-5 and 3460-3465.
// - sectors after each defect area within its tracks classify as reserved.
// - a defect area holds a definition sector, a primary and secondary list.
// - area offset 0 is definition sector, offset 1 starts primary list, secondary follows.
// - list lengths come from their counts; sectors past secondary list are unspecified.
// - bands after 0 start with buffer; every band ends buffer, test, buffer.
// - sector-mark-only buffer tracks are numbered and reported as their own region.
// - buffer and test addresses are flagged as not permitted for user data.
// - per-band constants give data, spare, buffer and test starts; zone ends 32471.
// - seventeen sectors make one logical track; tracks count from 0.
// - tracks 0 to 32471 form the data zone; anything else is outside.
// - track/sector boundaries compare on the full track and sector pair.
// - first area is 0/0 to 2/6, rest of track 2 reserved; others alike.
package dzrc_pkg;

  localparam int unsigned DZRC_TRACK_W          = 16;
  localparam int unsigned DZRC_SECTOR_W         = 5;
  localparam int unsigned DZRC_BAND_W           = 4;
  localparam int unsigned DZRC_KEY_W            = DZRC_TRACK_W + DZRC_SECTOR_W;
  localparam int unsigned DZRC_BANDS            = 12;
  localparam int unsigned DZRC_AREAS            = 4;
  localparam int unsigned DZRC_OFFS_W           = 6;
  localparam int unsigned DZRC_COUNT_W          = 6;

  localparam logic [DZRC_OFFS_W-1:0] DZRC_SECTORS_PER_TRACK = 6'h11;
  localparam logic [DZRC_SECTOR_W-1:0] DZRC_LAST_SECTOR     = 5'h10;
  localparam logic [DZRC_OFFS_W-1:0] DZRC_AREA_LEN          = 6'h29;
  localparam logic [DZRC_OFFS_W-1:0] DZRC_LIST_START        = 6'h01;
  localparam logic [DZRC_TRACK_W-1:0] DZRC_AREA_TRACKS_M1   = 16'h0002;
  localparam logic [DZRC_TRACK_W-1:0] DZRC_ZONE_LAST_TRACK  = 16'h7ed7;
  localparam logic [DZRC_TRACK_W-1:0] DZRC_B0_LEAD_LAST     = 16'h0005;
  localparam logic [DZRC_TRACK_W-1:0] DZRC_B0_RSVD_LAST     = 16'h0019;
  localparam logic [DZRC_TRACK_W-1:0] DZRC_B0_TAIL_FIRST    = 16'h0d84;
  localparam logic [DZRC_TRACK_W-1:0] DZRC_B0_TAIL_LAST     = 16'h0d89;

  // first track of each defect area
  localparam int unsigned DZRC_AREA_BASE [DZRC_AREAS] = '{0, 3, 3460, 3463};

  // band tables; track numbers kept decimal so they read against the layout
  localparam int unsigned DZRC_BAND_START [DZRC_BANDS] =
    '{0, 3550, 6958, 10224, 13348, 16330, 19170, 21868, 24424, 26838, 29110, 31240};
  localparam int unsigned DZRC_HDR_TRK [DZRC_BANDS] =
    '{0, 3592, 6985, 10236, 13360, 16341, 19181, 21878, 24434, 26847, 29118, 31248};
  localparam int unsigned DZRC_HDR_SEC [DZRC_BANDS] = '{0, 6, 1, 16, 6, 13, 3, 10, 0, 7, 14, 4};
  localparam int unsigned DZRC_DATA_START [DZRC_BANDS] =
    '{26, 3608, 7000, 10250, 13374, 16354, 19194, 21890, 24444, 26858, 29128, 31258};
  localparam int unsigned DZRC_SPARE_START [DZRC_BANDS] =
    '{3435, 6866, 10148, 13275, 16257, 19100, 21798, 24357, 26773, 29046, 31178, 32420};
  localparam int unsigned DZRC_END_BUF_A [DZRC_BANDS] =
    '{3466, 6890, 10172, 13298, 16280, 19122, 21820, 24378, 26794, 29066, 31198, 32439};
  localparam int unsigned DZRC_TEST_START [DZRC_BANDS] =
    '{3469, 6893, 10175, 13301, 16283, 19125, 21823, 24381, 26797, 29069, 31201, 32442};
  localparam int unsigned DZRC_END_BUF_B [DZRC_BANDS] =
    '{3490, 6914, 10196, 13322, 16304, 19146, 21844, 24402, 26818, 29090, 31222, 32463};
  // band 11 has no trailing mark-only buffer: start placed past the zone end
  localparam int unsigned DZRC_MARK_TRK_GROOVE [DZRC_BANDS] =
    '{3505, 6929, 10210, 13335, 16317, 19158, 21856, 24413, 26828, 29100, 31231, 32472};
  localparam int unsigned DZRC_MARK_TRK_LAND [DZRC_BANDS] =
    '{3505, 6929, 10210, 13325, 16317, 19158, 21856, 24413, 26828, 29100, 31231, 32472};
  localparam int unsigned DZRC_MARK_SEC [DZRC_BANDS] = '{15, 13, 8, 1, 11, 4, 14, 7, 0, 10, 3, 0};

  typedef enum logic [3:0] {
    DZRC_RGN_OUTSIDE,
    DZRC_RGN_BUF_SECTOR_MARK_ONLY,
    DZRC_RGN_BUF_HEADER,
    DZRC_RGN_TEST,
    DZRC_RGN_RESERVED,
    DZRC_RGN_USER_DATA,
    DZRC_RGN_SPARE,
    DZRC_RGN_DEFECT_AREA
  } dzrc_region_t;

  typedef enum logic [2:0] {
    DZRC_SUB_NONE,
    DZRC_SUB_DISK_DEFINITION_SECTOR,
    DZRC_SUB_PRIMARY_DEFECT_LIST,
    DZRC_SUB_SECONDARY_DEFECT_LIST,
    DZRC_SUB_UNSPECIFIED
  } dzrc_sub_t;

  typedef struct packed {
    logic [DZRC_TRACK_W-1:0]  track;
    logic [DZRC_SECTOR_W-1:0] sector;
    logic                     groove;
  } dzrc_req_t;

  typedef struct packed {
    logic                    initialised;
    logic [DZRC_COUNT_W-1:0] primarySectors;
    logic [DZRC_COUNT_W-1:0] secondarySectors;
  } dzrc_lists_t;

  typedef struct packed {
    dzrc_region_t           region;
    logic [DZRC_BAND_W-1:0] band;
    logic                   userPermitted;
    logic [1:0]             areaIndex;
    dzrc_sub_t              areaSub;
  } dzrc_resp_t;

  function automatic logic [DZRC_KEY_W-1:0] dzrcKey(input int unsigned trk, input int unsigned sec);
    logic [31:0] t;
    logic [31:0] s;
    t = trk;
    s = sec;
    return {t[DZRC_TRACK_W-1:0], s[DZRC_SECTOR_W-1:0]};
  endfunction

endpackage

// file: verilog/dzrc_band_lookup.sv
// band index of a logical track
`timescale 1ns/1ps
module dzrc_band_lookup (
  input  wire logic [dzrc_pkg::DZRC_TRACK_W-1:0] track,
  output logic      [dzrc_pkg::DZRC_BAND_W-1:0]  band
);

  always_comb begin
    band = '0;
    // last band whose start lies at or below the track wins
    for (int i = 0; i < int'(dzrc_pkg::DZRC_BANDS); i++) begin
      if (32'(track) >= dzrc_pkg::DZRC_BAND_START[i]) begin
        band = dzrc_pkg::DZRC_BAND_W'(i);
      end
    end
  end

endmodule

// file: verilog/dzrc_defect_area.sv
// defect area hit, index and sub-area of a groove address
`timescale 1ns/1ps
module dzrc_defect_area (
  input  wire dzrc_pkg::dzrc_req_t   req,
  input  wire dzrc_pkg::dzrc_lists_t lists,
  output logic                       inTracks,
  output logic                       inArea,
  output logic [1:0]                 areaIndex,
  output dzrc_pkg::dzrc_sub_t        areaSub
);

  logic [dzrc_pkg::DZRC_TRACK_W-1:0] relTrack;
  logic [dzrc_pkg::DZRC_OFFS_W-1:0]  offs;
  logic [dzrc_pkg::DZRC_OFFS_W:0]    primaryEnd;
  logic [dzrc_pkg::DZRC_OFFS_W:0]    secondaryEnd;

  always_comb begin
    inTracks  = 1'b0;
    areaIndex = 2'h0;
    relTrack  = '0;
    for (int i = 0; i < int'(dzrc_pkg::DZRC_AREAS); i++) begin
      if (req.groove && 32'(req.track) >= dzrc_pkg::DZRC_AREA_BASE[i] &&
          32'(req.track) <= dzrc_pkg::DZRC_AREA_BASE[i] + 32'(dzrc_pkg::DZRC_AREA_TRACKS_M1)) begin
        inTracks  = 1'b1;
        areaIndex = 2'(i);
        relTrack  = req.track - dzrc_pkg::DZRC_TRACK_W'(dzrc_pkg::DZRC_AREA_BASE[i]);
      end
    end
    // linear sector offset inside the three tracks of an area
    offs = 6'(relTrack[1:0]) * dzrc_pkg::DZRC_SECTORS_PER_TRACK + 6'(req.sector);
    inArea = inTracks && offs < dzrc_pkg::DZRC_AREA_LEN;
    primaryEnd   = 7'(dzrc_pkg::DZRC_LIST_START) + 7'(lists.primarySectors);
    secondaryEnd = primaryEnd + 7'(lists.secondarySectors);
    areaSub = dzrc_pkg::DZRC_SUB_NONE;
    if (inArea) begin
      // an uninitialised area has no structure to point into
      if (!lists.initialised) begin
        areaSub = dzrc_pkg::DZRC_SUB_UNSPECIFIED;
      end else if (offs == '0) begin
        areaSub = dzrc_pkg::DZRC_SUB_DISK_DEFINITION_SECTOR;
      end else if (7'(offs) < primaryEnd) begin
        areaSub = dzrc_pkg::DZRC_SUB_PRIMARY_DEFECT_LIST;
      end else if (7'(offs) < secondaryEnd) begin
        areaSub = dzrc_pkg::DZRC_SUB_SECONDARY_DEFECT_LIST;
      end else begin
        areaSub = dzrc_pkg::DZRC_SUB_UNSPECIFIED;
      end
    end
  end

endmodule

// file: verilog/dzrc_classifier.sv
// data zone region classifier top: combinational decode, registered answer
`timescale 1ns/1ps
module dzrc_classifier (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  reqValid,
  input  wire dzrc_pkg::dzrc_req_t   req,
  input  wire dzrc_pkg::dzrc_lists_t lists,
  output logic                       respValid,
  output dzrc_pkg::dzrc_resp_t       resp
);

  typedef struct packed {
    logic                 valid;
    dzrc_pkg::dzrc_resp_t resp;
  } dzrc_state_t;

  dzrc_state_t state_q;
  dzrc_state_t state_d;

  logic [dzrc_pkg::DZRC_BAND_W-1:0] band;
  logic                             areaTracks;
  logic                             areaHit;
  logic [1:0]                       areaIndex;
  dzrc_pkg::dzrc_sub_t              areaSub;
  logic [dzrc_pkg::DZRC_KEY_W-1:0]  key;
  dzrc_pkg::dzrc_region_t           region;

  dzrc_band_lookup u_band (
    .track (req.track),
    .band  (band)
  );

  dzrc_defect_area u_area (
    .req       (req),
    .lists     (lists),
    .inTracks  (areaTracks),
    .inArea    (areaHit),
    .areaIndex (areaIndex),
    .areaSub   (areaSub)
  );

  // band-generic walk from the data start to the band end
  function automatic dzrc_pkg::dzrc_region_t tailRegion(
    input logic [dzrc_pkg::DZRC_KEY_W-1:0]  k,
    input logic [dzrc_pkg::DZRC_BAND_W-1:0] b,
    input logic                             groove
  );
    int unsigned markTrk;
    markTrk = groove ? dzrc_pkg::DZRC_MARK_TRK_GROOVE[b] : dzrc_pkg::DZRC_MARK_TRK_LAND[b];
    if (k < dzrc_pkg::dzrcKey(dzrc_pkg::DZRC_SPARE_START[b], 0)) begin
      return dzrc_pkg::DZRC_RGN_USER_DATA;
    end else if (k < dzrc_pkg::dzrcKey(dzrc_pkg::DZRC_END_BUF_A[b], 0)) begin
      return dzrc_pkg::DZRC_RGN_SPARE;
    end else if (k < dzrc_pkg::dzrcKey(dzrc_pkg::DZRC_TEST_START[b], 0)) begin
      return dzrc_pkg::DZRC_RGN_BUF_HEADER;
    end else if (k < dzrc_pkg::dzrcKey(dzrc_pkg::DZRC_END_BUF_B[b], 0)) begin
      return dzrc_pkg::DZRC_RGN_TEST;
    end else if (k < dzrc_pkg::dzrcKey(markTrk, dzrc_pkg::DZRC_MARK_SEC[b])) begin
      return dzrc_pkg::DZRC_RGN_BUF_HEADER;
    end else begin
      return dzrc_pkg::DZRC_RGN_BUF_SECTOR_MARK_ONLY;
    end
  endfunction

  always_comb begin
    key    = {req.track, req.sector};
    region = dzrc_pkg::DZRC_RGN_OUTSIDE;
    // sector numbers above the last one of a track are not addresses
    if (req.track > dzrc_pkg::DZRC_ZONE_LAST_TRACK || req.sector > dzrc_pkg::DZRC_LAST_SECTOR) begin
      region = dzrc_pkg::DZRC_RGN_OUTSIDE;
    end else if (band == '0) begin
      if (areaTracks) begin
        region = areaHit ? dzrc_pkg::DZRC_RGN_DEFECT_AREA : dzrc_pkg::DZRC_RGN_RESERVED;
      end else if (req.track <= dzrc_pkg::DZRC_B0_LEAD_LAST && req.groove) begin
        region = dzrc_pkg::DZRC_RGN_RESERVED;
      end else if (req.track <= dzrc_pkg::DZRC_B0_RSVD_LAST) begin
        // land side of the lead tracks holds no defect area
        region = dzrc_pkg::DZRC_RGN_RESERVED;
      end else if (req.track >= dzrc_pkg::DZRC_B0_TAIL_FIRST && req.track <= dzrc_pkg::DZRC_B0_TAIL_LAST) begin
        region = dzrc_pkg::DZRC_RGN_RESERVED;
      end else begin
        region = tailRegion(key, band, req.groove);
      end
    end else if (key < dzrc_pkg::dzrcKey(dzrc_pkg::DZRC_HDR_TRK[band], dzrc_pkg::DZRC_HDR_SEC[band])) begin
      region = dzrc_pkg::DZRC_RGN_BUF_SECTOR_MARK_ONLY;
    end else if (key < dzrc_pkg::dzrcKey(dzrc_pkg::DZRC_DATA_START[band], 0)) begin
      region = dzrc_pkg::DZRC_RGN_BUF_HEADER;
    end else begin
      region = tailRegion(key, band, req.groove);
    end
  end

  always_comb begin
    state_d       = state_q;
    state_d.valid = reqValid;
    if (reqValid) begin
      state_d.resp.region        = region;
      state_d.resp.band          = (region == dzrc_pkg::DZRC_RGN_OUTSIDE) ? '0 : band;
      // spare holds relocated user sectors, so it stays writable
      state_d.resp.userPermitted = region == dzrc_pkg::DZRC_RGN_USER_DATA ||
                                   region == dzrc_pkg::DZRC_RGN_SPARE;
      state_d.resp.areaIndex     = (region == dzrc_pkg::DZRC_RGN_DEFECT_AREA ||
                                    region == dzrc_pkg::DZRC_RGN_RESERVED) && areaTracks ? areaIndex : 2'h0;
      state_d.resp.areaSub       = (region == dzrc_pkg::DZRC_RGN_DEFECT_AREA) ? areaSub : dzrc_pkg::DZRC_SUB_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign respValid = state_q.valid;
  assign resp      = state_q.resp;

endmodule

// file: verification/dzrc_classifier_assertions.sv
// concurrent checks on the classifier ports
`timescale 1ns/1ps
module dzrc_classifier_assertions (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  reqValid,
  input wire dzrc_pkg::dzrc_req_t   req,
  input wire dzrc_pkg::dzrc_lists_t lists,
  input wire logic                  respValid,
  input wire dzrc_pkg::dzrc_resp_t  resp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take;
    reqValid && req.sector <= 5'h10 && req.track <= 16'h7ed7;
  endsequence
  sequence s_areaStart;
    s_take ##0 (req.groove && lists.initialised && req.sector == 5'h00 && req.track inside {0, 3, 3460, 3463});
  endsequence
  property p_answer; reqValid |=> respValid; endproperty
  property p_hold; !reqValid |=> !respValid && $stable(resp); endproperty
  // reset must win even while the default disable is active
  property p_clear; disable iff (1'b0) rst |=> !respValid && resp == '0; endproperty
  property p_permit;
    respValid |-> resp.userPermitted == (resp.region inside {dzrc_pkg::DZRC_RGN_USER_DATA, dzrc_pkg::DZRC_RGN_SPARE});
  endproperty
  property p_subNone;
    respValid && resp.region != dzrc_pkg::DZRC_RGN_DEFECT_AREA |-> resp.areaSub == dzrc_pkg::DZRC_SUB_NONE;
  endproperty
  property p_outside;
    reqValid && (req.track > 16'h7ed7 || req.sector > 5'h10) |=>
      resp.region == dzrc_pkg::DZRC_RGN_OUTSIDE && resp.band == 4'h0;
  endproperty
  property p_land; reqValid && !req.groove |=> resp.region != dzrc_pkg::DZRC_RGN_DEFECT_AREA; endproperty
  property p_defSector;
    s_areaStart |=> resp.region == dzrc_pkg::DZRC_RGN_DEFECT_AREA && resp.areaSub == dzrc_pkg::DZRC_SUB_DISK_DEFINITION_SECTOR;
  endproperty
  property p_tail;
    s_take ##0 (req.groove && req.track inside {2, 5, 3462, 3465} && req.sector >= 5'h07) |=>
      resp.region == dzrc_pkg::DZRC_RGN_RESERVED;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  a_hold: assert property (p_hold) else $error("answer moved without request");
  a_clear: assert property (p_clear) else $error("reset left answer set");
  a_permit: assert property (p_permit) else $error("permit flag wrong for region");
  a_subNone: assert property (p_subNone) else $error("sub-area outside defect area");
  a_outside: assert property (p_outside) else $error("address past zone not outside");
  a_land: assert property (p_land) else $error("land address in defect area");
  a_defSector: assert property (p_defSector) else $error("area start not definition sector");
  a_tail: assert property (p_tail) else $error("area tail not reserved");
endmodule
bind dzrc_classifier dzrc_classifier_assertions i_chk (.clock(clock), .rst(rst), .reqValid(reqValid), .req(req),
  .lists(lists), .respValid(respValid), .resp(resp));

// file: verification/dzrc_requester.sv
// requester model: presents track, sector and groove selection
`timescale 1ns/1ps
module dzrc_requester (
  input  wire logic             clock,
  output logic                  reqValid,
  output dzrc_pkg::dzrc_req_t   req,
  output dzrc_pkg::dzrc_lists_t lists
);
  initial begin
    reqValid = 1'b0;
    req      = '0;
    lists    = '0;
  end
  task automatic push(input dzrc_pkg::dzrc_req_t r, input dzrc_pkg::dzrc_lists_t l);
    @(posedge clock);
    reqValid <= 1'b1;
    req      <= r;
    lists    <= l;
  endtask
  // released lines scrambled so a stale address is never trusted
  task automatic idle();
    @(posedge clock);
    reqValid <= 1'b0;
    req      <= ~req;
  endtask
endmodule

// file: verification/tb.sv
// self-checking bench of the data zone region classifier
`timescale 1ns/1ps
module tb;
  localparam dzrc_pkg::dzrc_region_t R_OUT = dzrc_pkg::DZRC_RGN_OUTSIDE, R_MARK = dzrc_pkg::DZRC_RGN_BUF_SECTOR_MARK_ONLY,
    R_HDR = dzrc_pkg::DZRC_RGN_BUF_HEADER, R_TST = dzrc_pkg::DZRC_RGN_TEST, R_RSV = dzrc_pkg::DZRC_RGN_RESERVED,
    R_USR = dzrc_pkg::DZRC_RGN_USER_DATA, R_SPR = dzrc_pkg::DZRC_RGN_SPARE, R_AREA = dzrc_pkg::DZRC_RGN_DEFECT_AREA;
  localparam dzrc_pkg::dzrc_sub_t S_NO = dzrc_pkg::DZRC_SUB_NONE, S_DEF = dzrc_pkg::DZRC_SUB_DISK_DEFINITION_SECTOR,
    S_PRI = dzrc_pkg::DZRC_SUB_PRIMARY_DEFECT_LIST, S_SEC = dzrc_pkg::DZRC_SUB_SECONDARY_DEFECT_LIST,
    S_UNS = dzrc_pkg::DZRC_SUB_UNSPECIFIED;
  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  logic                  reqValid;
  dzrc_pkg::dzrc_req_t   req;
  dzrc_pkg::dzrc_lists_t lists;
  logic                  respValid;
  dzrc_pkg::dzrc_resp_t  resp;
  int                    n_checks = 0;
  int                    miscompares = 0;
  always #2.5 clock = ~clock;
  dzrc_requester i_req (.clock(clock), .reqValid(reqValid), .req(req), .lists(lists));
  dzrc_classifier i_dut (.clock(clock), .rst(rst), .reqValid(reqValid), .req(req), .lists(lists),
    .respValid(respValid), .resp(resp));
  task automatic cmpVec(input string n, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic judge(input dzrc_pkg::dzrc_region_t er, input logic [3:0] eb, input dzrc_pkg::dzrc_sub_t es,
      input logic [1:0] ei);
    cmpVec("respValid", 4'h1, {3'h0, respValid});
    cmpVec("region", er, resp.region);
    cmpVec("band", eb, resp.band);
    cmpVec("areaSub", {1'b0, es}, {1'b0, resp.areaSub});
    cmpVec("areaIndex", {2'h0, ei}, {2'h0, resp.areaIndex});
    cmpVec("userPermitted", {3'h0, (er inside {R_USR, R_SPR})}, {3'h0, resp.userPermitted});
  endtask
  task automatic run(input int t, input int s, input logic g, input dzrc_pkg::dzrc_region_t er,
      input logic [3:0] eb = 4'h0, input dzrc_pkg::dzrc_sub_t es = S_NO, input logic [1:0] ei = 2'h0,
      input logic in = 1'b1, input int p = 2);
    i_req.push('{t[15:0], s[4:0], g}, '{in, p[5:0], 6'h01});
    i_req.idle();
    #1;
    judge(er, eb, es, ei);
  endtask
  task automatic s_defectArea();
    run(0, 0, 1, R_AREA, 0, S_DEF);
    run(0, 2, 1, R_AREA, 0, S_PRI);
    run(0, 3, 1, R_AREA, 0, S_SEC);
    run(0, 4, 1, R_AREA, 0, S_UNS);
    run(2, 6, 1, R_AREA, 0, S_UNS);
    run(2, 7, 1, R_RSV);
    run(5, 16, 1, R_RSV, 0, S_NO, 1);
    run(3, 1, 1, R_AREA, 0, S_PRI, 1);
    run(3460, 0, 1, R_AREA, 0, S_DEF, 2);
    run(3463, 1, 1, R_AREA, 0, S_SEC, 3, 1, 0);
    run(3465, 7, 1, R_RSV, 0, S_NO, 3);
    run(1, 5, 1, R_AREA, 0, S_UNS, 0, 0);
    run(6, 0, 1, R_RSV);
    run(0, 0, 0, R_RSV);
  endtask
  task automatic s_layout();
    run(26, 0, 1, R_USR);
    run(3434, 16, 1, R_USR);
    run(3435, 0, 0, R_SPR);
    run(3466, 0, 1, R_HDR);
    run(3469, 0, 1, R_TST);
    run(3505, 14, 1, R_HDR);
    run(3505, 15, 1, R_MARK);
    run(3592, 5, 0, R_MARK, 1);
    run(3592, 6, 1, R_HDR, 1);
    run(13335, 0, 1, R_HDR, 3);
    run(13325, 1, 0, R_MARK, 3);
    run(32471, 16, 1, R_HDR, 11);
    run(32472, 0, 1, R_OUT);
    run(26, 17, 1, R_OUT);
  endtask
  // two requests on consecutive edges, then a reset in mid-run
  task automatic s_backToBack();
    i_req.push('{16'h001a, 5'h00, 1'b1}, '{1'b1, 6'h02, 6'h01});
    i_req.push('{16'h0d8d, 5'h00, 1'b1}, '{1'b1, 6'h02, 6'h01});
    #1;
    judge(R_USR, 0, S_NO, 0);
    i_req.idle();
    #1;
    judge(R_TST, 0, S_NO, 0);
    @(posedge clock);
    #1;
    cmpVec("respValid", 4'h0, {3'h0, respValid});
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    cmpVec("region", 4'h0, resp.region);
    cmpVec("respValid", 4'h0, {3'h0, respValid});
    // first request straight after release, land side of the inner areas
    run(3460, 0, 0, R_RSV);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    s_defectArea();
    s_layout();
    s_backToBack();
    conclude();
  end
endmodule
